// file: hw/usb_setup_pkg.sv
// Purpose: shared constants for the setup capture and control buffer block
// Assumes: APB with 32-bit data, 16-bit registers in the low half of a word
// Notes: printed offsets are not all multiples of four, so they are indices
package usb_setup_pkg;
  // Register indices as printed; byte address is four times the index
  localparam logic [7:0] IDX_REQ_TYPE = 8'h20;
  localparam logic [7:0] IDX_VALUE = 8'h22;
  localparam logic [7:0] IDX_INDEX = 8'h24;
  localparam logic [7:0] IDX_LENGTH = 8'h26;
  localparam logic [7:0] IDX_CTL_CFG = 8'h28;
  localparam logic [7:0] IDX_CTL_STATUS = 8'h30;
  localparam logic [7:0] IDX_SOFT_RESET = 8'h32;
  // Reset values
  localparam logic [15:0] CAPTURE_RESET = 16'h0000;
  localparam logic [15:0] CFG_RESET = 16'h0000;
  // Configuration fields
  localparam int CFG_RD_CONT_BIT = 15;
  localparam int CFG_RD_BLK_HI = 13;
  localparam int CFG_RD_BLK_LO = 8;
  localparam int CFG_WR_CONT_BIT = 7;
  localparam int CFG_WR_BLK_HI = 5;
  localparam int CFG_WR_BLK_LO = 0;
  localparam logic [15:0] CFG_WRITABLE = 16'hBFBF;
  // Buffer geometry
  localparam logic [5:0] BLK_LAST = 6'h2F;
  localparam int BLK_BYTES = 64;
  localparam int CONT_BYTES = 256;
  localparam logic [8:0] CONT_BYTES_W = 9'h100;
  localparam logic [5:0] CONT_BLOCKS = 6'h04;
  localparam logic [5:0] ONE_BLOCK = 6'h01;
  localparam logic [2:0] SETUP_BYTES = 3'h7;
  // Unmapped-address answer
  localparam logic [31:0] READ_ZERO = 32'h0000_0000;
endpackage

// file: hw/setup_byte_collector.sv
// Purpose: gather the eight setup bytes and publish them at once
// Assumes: bytes arrive from the link logic on pclk, low byte first
// Notes: a packet that ends early or fails its check is dropped whole
`timescale 1ns/1ps
`default_nettype none
module setup_byte_collector (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic byte_valid,
  input wire logic [7:0] byte_data,
  input wire logic pkt_start,
  input wire logic pkt_good,
  output logic [63:0] packet,
  output logic packet_done
);
  logic [2:0] count_reg;
  logic [63:0] shift_reg;
  logic full_reg;

  // Byte gathering, first byte lands lowest
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_reg <= 3'h0;
      shift_reg <= 64'h0000_0000_0000_0000;
      full_reg <= 1'b0;
    end else if (pkt_start) begin
      count_reg <= 3'h0;
      full_reg <= 1'b0;
    end else if (byte_valid && !full_reg) begin
      shift_reg <= {byte_data, shift_reg[63:8]}; // R18
      count_reg <= count_reg + 3'h1;
      if (count_reg == usb_setup_pkg::SETUP_BYTES) begin
        full_reg <= 1'b1;
      end
    end
  end

  // Publish only a complete, checked packet
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      packet <= 64'h0000_0000_0000_0000;
      packet_done <= 1'b0;
    end else begin
      packet_done <= pkt_good && full_reg; // R18
      if (pkt_good && full_reg) begin
        packet <= shift_reg;
      end
    end
  end
endmodule // setup_byte_collector
`default_nettype wire

// file: hw/usb_setup_capture_ctrl_buf.sv
// Purpose: setup request capture and control transfer buffer settings
// Assumes: APB slave on pclk; setup bytes arrive from same-domain link logic
// Notes: capture registers are read-only; configuration survives software reset
// Function
// R1: request code byte goes to the high byte of the request-type register
// R2: request-type byte goes to the low byte of the request-type register
// R3: wValue fills all bits of the value register
// R4: wIndex fills the index register
// R5: wLength fills the length register
// R6: software writes to capture registers do nothing
// R7: capture registers clear on hardware and software reset, keep on bus reset
// R8: bit 15 picks single or continuous control-read transmit
// R9: bits 13..8 give the control-read start block
// R10: bit 7 picks unit or continuous control-write receive
// R11: bits 5..0 give the control-write start block
// R12: software writes zero to reserved bits 14 and 6
// R13: configuration clears on hardware reset only
// R14: a block is 64 bytes, valid numbers 0x00 to 0x2F
// R15: continuous transmit spans the set length up to 256 bytes
// R16: continuous receive spans 256 bytes, ends at 256 or a short packet
// R17: unit receive ends after one full or short packet
// R18: all four capture registers update together, low byte first
//
// The APB register port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module usb_setup_capture_ctrl_buf (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic usb_bus_reset,
  input wire logic setup_byte_valid,
  input wire logic [7:0] setup_byte_data,
  input wire logic setup_pkt_start,
  input wire logic setup_pkt_good,
  input wire logic [8:0] rd_cont_length,
  input wire logic wr_pkt_done,
  input wire logic wr_pkt_short,
  input wire logic [6:0] wr_pkt_bytes,
  output logic rd_continuous,
  output logic [5:0] rd_first_block,
  output logic [5:0] rd_last_block,
  output logic wr_continuous,
  output logic [5:0] wr_first_block,
  output logic [5:0] wr_last_block,
  output logic wr_stage_done,
  output logic setup_captured,
  output logic block_range_error
);
  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic [15:0] req_type_reg;
  logic [15:0] value_reg;
  logic [15:0] index_reg;
  logic [15:0] length_reg;
  logic [15:0] cfg_reg;
  logic [8:0] wr_count_reg;
  logic soft_reset_reg;
  logic [63:0] packet;
  logic packet_done;
  logic wr_en;
  logic [9:0] index;
  logic [5:0] rd_span;
  logic [8:0] wr_total;

  // Blocks needed for a byte count, rounded up to whole 64-byte blocks
  function automatic logic [5:0] blocks_for(input logic [8:0] bytes);
    logic [8:0] rounded;
    rounded = bytes + 9'(usb_setup_pkg::BLK_BYTES - 1);
    blocks_for = {3'h0, rounded[8:6]};
  endfunction

  // Register select for the word index on the bus
  function automatic logic reg_hit(input logic [9:0] word, input logic [7:0] reg_idx);
    reg_hit = (word == {2'b00, reg_idx});
  endfunction

  // Last block of a span, held at zero span minimum of one block
  function automatic logic [5:0] last_block(input logic [5:0] first, input logic [5:0] span);
    last_block = (span == 6'h00) ? first : first + span - usb_setup_pkg::ONE_BLOCK;
  endfunction

  // ----------------------------------------
  // Setup packet capture
  // ----------------------------------------
  setup_byte_collector collector (
    .pclk(pclk),
    .presetn(presetn),
    .byte_valid(setup_byte_valid),
    .byte_data(setup_byte_data),
    .pkt_start(setup_pkt_start),
    .pkt_good(setup_pkt_good),
    .packet(packet),
    .packet_done(packet_done)
  );

  // APB: zero wait states, word addressed
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign index = paddr[11:2];
  assign wr_en = psel && penable && pwrite;

  // Capture registers; bus reset does not touch them, writes ignored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_type_reg <= usb_setup_pkg::CAPTURE_RESET; // R7
      value_reg <= usb_setup_pkg::CAPTURE_RESET;
      index_reg <= usb_setup_pkg::CAPTURE_RESET;
      length_reg <= usb_setup_pkg::CAPTURE_RESET;
    end else if (packet_done) begin
      req_type_reg <= {packet[15:8], packet[7:0]}; // R1 R2 R18
      value_reg <= packet[31:16]; // R3
      index_reg <= packet[47:32]; // R4
      length_reg <= packet[63:48]; // R5
    end else if (soft_reset_reg) begin
      req_type_reg <= usb_setup_pkg::CAPTURE_RESET; // R7 R6
      value_reg <= usb_setup_pkg::CAPTURE_RESET;
      index_reg <= usb_setup_pkg::CAPTURE_RESET;
      length_reg <= usb_setup_pkg::CAPTURE_RESET;
    end
  end

  // Software reset pulse, self clearing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      soft_reset_reg <= 1'b0;
    end else begin
      soft_reset_reg <= wr_en && reg_hit(index, usb_setup_pkg::IDX_SOFT_RESET) && pwdata[0];
    end
  end

  // Configuration register, hardware reset only, reserved bits forced zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_reg <= usb_setup_pkg::CFG_RESET; // R13
    end else if (wr_en && reg_hit(index, usb_setup_pkg::IDX_CTL_CFG)) begin
      cfg_reg <= pwdata[15:0] & usb_setup_pkg::CFG_WRITABLE; // R12 R13
    end
  end

  // Read data from flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= usb_setup_pkg::READ_ZERO;
    end else if (psel && !penable && !pwrite) begin
      unique case (index)
        {2'b00, usb_setup_pkg::IDX_REQ_TYPE}: prdata <= {16'h0000, req_type_reg}; // R1
        {2'b00, usb_setup_pkg::IDX_VALUE}: prdata <= {16'h0000, value_reg};
        {2'b00, usb_setup_pkg::IDX_INDEX}: prdata <= {16'h0000, index_reg};
        {2'b00, usb_setup_pkg::IDX_LENGTH}: prdata <= {16'h0000, length_reg};
        {2'b00, usb_setup_pkg::IDX_CTL_CFG}: prdata <= {16'h0000, cfg_reg};
        {2'b00, usb_setup_pkg::IDX_CTL_STATUS}: prdata <= {16'h0000, 5'h00, block_range_error,
          wr_stage_done, wr_count_reg};
        default: prdata <= usb_setup_pkg::READ_ZERO;
      endcase
    end
  end

  // ----------------------------------------
  // Buffer span decode
  // ----------------------------------------
  assign rd_continuous = cfg_reg[usb_setup_pkg::CFG_RD_CONT_BIT]; // R8
  assign rd_first_block = cfg_reg[usb_setup_pkg::CFG_RD_BLK_HI:usb_setup_pkg::CFG_RD_BLK_LO]; // R9
  assign wr_continuous = cfg_reg[usb_setup_pkg::CFG_WR_CONT_BIT]; // R10
  assign wr_first_block = cfg_reg[usb_setup_pkg::CFG_WR_BLK_HI:usb_setup_pkg::CFG_WR_BLK_LO]; // R11

  // Read span: set length capped at 256 bytes, or one block
  always_comb begin
    if (rd_continuous) begin
      rd_span = blocks_for((rd_cont_length > usb_setup_pkg::CONT_BYTES_W) ?
        usb_setup_pkg::CONT_BYTES_W : rd_cont_length); // R15
    end else begin
      rd_span = usb_setup_pkg::ONE_BLOCK; // R15
    end
  end
  assign rd_last_block = last_block(rd_first_block, rd_span);
  assign wr_last_block = last_block(wr_first_block,
    wr_continuous ? usb_setup_pkg::CONT_BLOCKS : usb_setup_pkg::ONE_BLOCK); // R16 R17

  // Span must stay inside blocks 0x00..0x2F
  assign block_range_error = (rd_last_block > usb_setup_pkg::BLK_LAST) ||
    (rd_last_block < rd_first_block) || (wr_last_block > usb_setup_pkg::BLK_LAST) ||
    (wr_last_block < wr_first_block); // R14

  // ----------------------------------------
  // Control-write data stage completion
  // ----------------------------------------
  assign wr_total = wr_count_reg + {2'b00, wr_pkt_bytes};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_count_reg <= 9'h000;
      wr_stage_done <= 1'b0;
    end else if (packet_done || usb_bus_reset) begin
      wr_count_reg <= 9'h000;
      wr_stage_done <= 1'b0;
    end else begin
      wr_stage_done <= 1'b0;
      if (wr_pkt_done) begin
        if (!wr_continuous || wr_pkt_short) begin
          wr_stage_done <= 1'b1; // R17 R16
          wr_count_reg <= 9'h000;
        end else if (wr_total >= usb_setup_pkg::CONT_BYTES_W) begin
          wr_stage_done <= 1'b1; // R16
          wr_count_reg <= 9'h000;
        end else begin
          wr_count_reg <= wr_total;
        end
      end
    end
  end

  // Capture pulse for the link logic
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      setup_captured <= 1'b0;
    end else begin
      setup_captured <= packet_done;
    end
  end
endmodule // usb_setup_capture_ctrl_buf
`default_nettype wire

// file: sim/host_link_model.sv
// Purpose: link-side stand-in feeding setup bytes and data packet ends
// Assumes: all traffic changes just after rising pclk edges
// Notes: released data lines show the inverse of their last value
`timescale 1ns/1ps
`default_nettype none
module host_link_model (
  input wire logic pclk,
  output logic byte_valid,
  output logic pkt_start,
  output logic pkt_good,
  output logic pkt_done,
  output logic pkt_short,
  output logic [7:0] byte_data,
  output logic [8:0] cont_length,
  output logic [6:0] pkt_bytes
);
  // Idle link at time zero
  initial begin
    {byte_valid, pkt_start, pkt_good, pkt_done, pkt_short} = 5'h00;
    byte_data = 8'hA5;
    cont_length = 9'h080;
    pkt_bytes = 7'h55;
  end
  // Setup packet, n bytes, low byte of each field first
  task automatic send_setup(input logic [63:0] p, input int n);
    pkt_start <= 1'b1;
    @(posedge pclk);
    pkt_start <= 1'b0;
    for (int i = 0; i < n; i++) begin
      byte_valid <= 1'b1;
      byte_data <= p[8*i +: 8];
      @(posedge pclk);
    end
    byte_valid <= 1'b0;
    byte_data <= ~byte_data;
    pkt_good <= 1'b1;
    @(posedge pclk);
    pkt_good <= 1'b0;
  endtask
  // Data packet end, then one idle cycle
  task automatic send_pkt(input logic [6:0] n, input logic s);
    {pkt_done, pkt_short, pkt_bytes} <= {1'b1, s, n};
    @(posedge pclk);
    {pkt_done, pkt_short, pkt_bytes} <= {2'b00, ~n};
    @(posedge pclk);
  endtask
endmodule // host_link_model
`default_nettype wire

// file: sim/setup_cap_sva.sv
// Purpose: port checker for the setup capture block
// Assumes: one pclk domain, async active-low reset
// Notes: bound to the design top
`timescale 1ns/1ps
`default_nettype none
module setup_cap_sva (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic rd_continuous,
  input wire logic wr_continuous,
  input wire logic wr_pkt_done,
  input wire logic wr_pkt_short,
  input wire logic wr_stage_done,
  input wire logic block_range_error,
  input wire logic [5:0] rd_first_block,
  input wire logic [5:0] rd_last_block,
  input wire logic [5:0] wr_first_block,
  input wire logic [5:0] wr_last_block
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Accepted configuration write; packet end that closes a stage
  sequence s_cfg_wr; psel && penable && pwrite && paddr == 12'h0A0; endsequence
  sequence s_end; wr_pkt_done && (wr_pkt_short || !wr_continuous); endsequence
  property p_rd_mode; s_cfg_wr |=> rd_continuous == $past(pwdata[15]); endproperty
  property p_rd_blk; s_cfg_wr |=> rd_first_block == $past(pwdata[13:8]); endproperty
  property p_wr_mode; s_cfg_wr |=> wr_continuous == $past(pwdata[7]); endproperty
  property p_wr_blk; s_cfg_wr |=> wr_first_block == $past(pwdata[5:0]); endproperty
  property p_rd_one; !rd_continuous |-> rd_last_block == rd_first_block; endproperty
  property p_wr_span;
    wr_continuous && wr_first_block < 6'h2D |-> wr_last_block == wr_first_block + 6'h03;
  endproperty
  property p_range;
    rd_first_block > usb_setup_pkg::BLK_LAST |-> block_range_error;
  endproperty
  property p_end; s_end |=> wr_stage_done; endproperty
  property p_wr_one; !wr_continuous |-> wr_last_block == wr_first_block; endproperty
  a_rd_mode: assert property (p_rd_mode) else $error("read mode not taken");
  a_rd_blk: assert property (p_rd_blk) else $error("read block not taken");
  a_wr_mode: assert property (p_wr_mode) else $error("write mode not taken");
  a_wr_blk: assert property (p_wr_blk) else $error("write block not taken");
  a_rd_one: assert property (p_rd_one) else $error("single read span");
  a_wr_span: assert property (p_wr_span) else $error("continuous write span");
  a_range: assert property (p_range) else $error("block range flag");
  a_end: assert property (p_end) else $error("stage not closed");
  a_wr_one: assert property (p_wr_one) else $error("unit write span");
endmodule // setup_cap_sva
bind usb_setup_capture_ctrl_buf setup_cap_sva u_setup_cap_sva (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .rd_continuous(rd_continuous),
  .wr_continuous(wr_continuous), .wr_pkt_done(wr_pkt_done), .wr_pkt_short(wr_pkt_short),
  .wr_stage_done(wr_stage_done), .block_range_error(block_range_error),
  .rd_first_block(rd_first_block), .rd_last_block(rd_last_block),
  .wr_first_block(wr_first_block), .wr_last_block(wr_last_block));
`default_nettype wire

// file: sim/tb.sv
// Purpose: self-checking bench for setup capture and control buffer block
// Assumes: link side played by host_link_model
// Notes: registers sit at four times their index
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam logic [11:0] A_TYPE = {2'h0, usb_setup_pkg::IDX_REQ_TYPE, 2'h0};
  localparam logic [11:0] A_CFG = {2'h0, usb_setup_pkg::IDX_CTL_CFG, 2'h0};
  localparam logic [63:0] PKT = 64'h0040_1234_0302_0680;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic bus_rst = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, q;
  logic pready, sbv, spst, spg, wpd, wps, rdc, wrc, wsd, bre, serr, scap;
  logic [7:0] sbd;
  logic [8:0] rcl;
  logic [6:0] wpb;
  logic [5:0] rfb, rlb, wfb, wlb;
  int err_total = 0;
  int checks = 0;
  int done_cnt = 0;
  int cap_cnt = 0;
  always #12.5 pclk = ~pclk;
  // Count stage completion and capture pulses
  always @(posedge pclk) begin
    if (wsd === 1'b1) done_cnt <= done_cnt + 1;
    if (scap === 1'b1) cap_cnt <= cap_cnt + 1;
  end
  usb_setup_capture_ctrl_buf u_usb_setup_capture_ctrl_buf (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(serr), .usb_bus_reset(bus_rst),
    .setup_byte_valid(sbv), .setup_byte_data(sbd), .setup_pkt_start(spst),
    .setup_pkt_good(spg), .rd_cont_length(rcl), .wr_pkt_done(wpd), .wr_pkt_short(wps),
    .wr_pkt_bytes(wpb), .rd_continuous(rdc), .rd_first_block(rfb), .rd_last_block(rlb),
    .wr_continuous(wrc), .wr_first_block(wfb), .wr_last_block(wlb), .wr_stage_done(wsd),
    .setup_captured(scap), .block_range_error(bre));
  host_link_model u_host_link_model (.pclk(pclk), .byte_valid(sbv), .byte_data(sbd),
    .pkt_start(spst), .pkt_good(spg), .cont_length(rcl), .pkt_done(wpd),
    .pkt_short(wps), .pkt_bytes(wpb));
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  // One APB transfer held until pready, then one idle cycle
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    {psel, penable} <= 2'b00;
    @(posedge pclk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(a, 1'b0, 32'h0);
    chk("prdata", e, q);
    chk("pslverr", 32'h0, {31'h0, serr});
  endtask
  // Four capture registers against one packet
  task automatic cap(input logic [63:0] p);
    for (int i = 0; i < 4; i++) rd(A_TYPE + 12'(8 * i), {16'h0000, p[16*i +: 16]});
  endtask
  task automatic stp(input logic [63:0] p, input int n);
    u_host_link_model.send_setup(p, n);
    repeat (3) @(posedge pclk);
  endtask
  task automatic pkt(input logic [6:0] n, input logic s, input int c);
    u_host_link_model.send_pkt(n, s);
    repeat (2) @(posedge pclk);
    chk("stage_done", c, done_cnt);
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Watchdog
  initial begin
    repeat (3000) @(posedge pclk);
    err_total++;
    end_of_test();
  end
  // Main sequence
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    cap(64'h0);
    rd(A_CFG, 32'h0);
    apb(A_CFG, 1'b1, 32'hBFBF);
    rd(A_CFG, 32'hBFBF);
    chk("range_err", 32'h1, {31'h0, bre});
    apb(A_CFG, 1'b1, 32'h8305);
    chk("cfg_out", 32'h2185, {18'h0, rdc, rfb, wrc, wfb});
    chk("rd_last", 32'h4, {26'h0, rlb});
    chk("wr_last", 32'h5, {26'h0, wlb});
    chk("range_err", 32'h0, {31'h0, bre});
    stp(PKT, 8);
    cap(PKT);
    chk("captured", 32'h1, cap_cnt);
    for (int i = 0; i < 4; i++) apb(A_TYPE + 12'(8 * i), 1'b1, 32'hFFFF);
    cap(PKT);
    stp(~PKT, 5);
    cap(PKT);
    chk("captured", 32'h1, cap_cnt);
    pkt(7'h40, 1'b0, 1);
    bus_rst <= 1'b1;
    @(posedge pclk);
    bus_rst <= 1'b0;
    cap(PKT);
    rd(A_CFG, 32'h8305);
    apb(A_CFG, 1'b1, 32'h0085);
    chk("rd_last", 32'h0, {26'h0, rlb});
    chk("wr_last", 32'h8, {26'h0, wlb});
    repeat (3) pkt(7'h40, 1'b0, 1);
    rd({2'h0, usb_setup_pkg::IDX_CTL_STATUS, 2'h0}, 32'h0000_00C0);
    pkt(7'h40, 1'b0, 2);
    pkt(7'h08, 1'b1, 3);
    apb({2'h0, usb_setup_pkg::IDX_SOFT_RESET, 2'h0}, 1'b1, 32'h1);
    repeat (2) @(posedge pclk);
    cap(64'h0);
    rd(A_CFG, 32'h0085);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    cap(64'h0);
    rd(A_CFG, 32'h0);
    end_of_test();
  end
endmodule // tb
`default_nettype wire
